// ===== common/iowst_regs.vh
// Register indices, field positions, reset values and timing constants of the I/O window block
`ifndef IOWST_REGS_VH
`define IOWST_REGS_VH

// ----------------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------------
`define IOWST_SPACE_HI      8'h80   // Offset bits [11:4] of the compatibility space (base + 800h)
`define IOWST_IDX_WIN_EN    4'h6    // Window enable register
`define IOWST_IDX_CTRL      4'h7    // io_window_control
`define IOWST_IDX_W0_BASE   4'h8    // io_window0_start_low, then start high, end low, end high
`define IOWST_IDX_W1_BASE   4'hc    // io_window1_start_low, then start high, end low, end high
`define IOWST_OFS_START_LO  2'h0
`define IOWST_OFS_START_HI  2'h1
`define IOWST_OFS_END_LO    2'h2
`define IOWST_OFS_END_HI    2'h3

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define IOWST_BIT_W0_EN     6
`define IOWST_BIT_W1_EN     7
`define IOWST_EN_RSVD_MASK  8'hdf   // Bit 5 of the enable register reads zero
`define IOWST_CTRL_NIB_W    4       // Control nibble width per window: long, short, auto, fixed
`define IOWST_NIB_LONG      3
`define IOWST_NIB_SHORT     2
`define IOWST_NIB_AUTO      1
`define IOWST_NIB_FIXED     0
`define IOWST_RST_BYTE      8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define IOWST_CLK_PERIOD_NS 20      // CORE_CLK period
`define IOWST_ISA_CYCLE_NS  125     // One ISA-equivalent bus cycle
`define IOWST_LEN_SHORT8    3'h3    // Shortened 8-bit cycle, in ISA cycles
`define IOWST_LEN_STD8      3'h4    // Standard 8-bit cycle, in ISA cycles
`define IOWST_LEN_STD16     3'h3    // Standard 16-bit cycle, in ISA cycles

`endif

// ===== rtl/iowst_win.v
// One I/O window: address match, transfer width and cycle length
`timescale 1ns/100ps
`default_nettype none
`include "iowst_regs.vh"

module iowst_win (
  input  wire [15:0] addr,      // Host I/O cycle address
  input  wire [15:0] start_addr,// Window start address
  input  wire [15:0] end_addr,  // Window end address
  input  wire        enable,    // Window enable bit
  input  wire [3:0]  ctrl,      // Window control nibble
  input  wire        card_wide, // Synchronised card 16-bit indication
  output wire        hit,       // Window claims this address
  output wire        wide,      // Transfer is 16 bits
  output wire [2:0]  len        // Cycle length in ISA cycles
);

  // ----------------------------------------------------------------------------
  // Decode and timing choice
  // ----------------------------------------------------------------------------
  // Disabled window never claims, inclusive range check
  assign hit  = enable && (addr >= start_addr) && (addr <= end_addr);
  // Auto sizing follows the card, else fixed bit
  assign wide = ctrl[`IOWST_NIB_AUTO] ? card_wide : ctrl[`IOWST_NIB_FIXED];
  // Long bit only stretches wide cycles, short bit only byte cycles
  assign len  = wide ? (`IOWST_LEN_STD16 + {2'h0, ctrl[`IOWST_NIB_LONG]})
                     : (ctrl[`IOWST_NIB_SHORT] ? `IOWST_LEN_SHORT8 : `IOWST_LEN_STD8);

endmodule
`default_nettype wire

// ===== rtl/iowst_top.v
// I/O window sizing and timing register bank with host cycle claim and timing
`timescale 1ns/100ps
`default_nettype none
`include "iowst_regs.vh"

// Overview of operation
// - Window 1 long bit stretches 16-bit cycles
// - Window 1 short bit cuts byte cycles to three
// - Window 1 auto bit takes width from card
// - Window 1 fixed bit: 0 byte, 1 word
// - Window 0 long bit stretches 16-bit cycles
// - Window 0 short bit cuts byte cycles to three
// - Window 0 auto bit takes width from card
// - Window 0 fixed bit: 0 byte, 1 word
// - Control register fully read/write, resets zero
// - Start low bytes read/write, reset zero
// - Registers mapped at base plus 800h plus index
// - Disabled window never claims host cycles
// - Start high and end bytes read/write, reset zero
module iowst_top (
  input  wire        CORE_CLK,       // Bus clock, 50 MHz
  input  wire        SYS_RST,        // Asynchronous reset, active high
  input  wire [11:0] REG_ADDR,       // Offset within the socket register space
  input  wire        REG_WE,         // Register write strobe, one cycle
  input  wire        REG_RE,         // Register read strobe, one cycle
  input  wire [7:0]  REG_WDATA,      // Register write data
  output reg  [7:0]  REG_RDATA,      // Register read data
  output reg         REG_ACK,        // Register access done, one cycle
  input  wire        IO_REQ,         // Host I/O cycle request, one cycle
  input  wire [15:0] IO_ADDR,        // Host I/O cycle address
  input  wire        CARD_WIDE_IO_N, // Card 16-bit I/O indication pin, active low
  output reg         IO_CLAIM,       // Cycle claimed, one cycle
  output reg         IO_WIN1,        // Claimed window is window 1
  output reg         IO_WIDE,        // Claimed cycle is 16 bits wide
  output reg         IO_BUSY,        // Card cycle in progress
  output reg         IO_DONE         // Card cycle finished, one cycle
);

  // ----------------------------------------------------------------------------
  // Constants and declarations
  // ----------------------------------------------------------------------------
  localparam [7:0] ISA_CLKS = (`IOWST_ISA_CYCLE_NS + `IOWST_CLK_PERIOD_NS - 1) / `IOWST_CLK_PERIOD_NS;
  localparam       ST_IDLE  = 1'b0;
  localparam       ST_RUN   = 1'b1;

  reg  [7:0]  ctrl_reg;
  reg  [7:0]  win_en_reg;
  reg  [7:0]  start_lo_reg [0:1];
  reg  [7:0]  start_hi_reg [0:1];
  reg  [7:0]  end_lo_reg   [0:1];
  reg  [7:0]  end_hi_reg   [0:1];
  reg         wide_sync1_reg;
  reg         wide_sync2_reg;
  reg         state_reg;
  reg  [7:0]  count_reg;
  reg  [7:0]  rdata_next;
  wire        in_space;
  wire [3:0]  idx;
  wire [1:0]  hit;
  wire [1:0]  wide;
  wire [2:0]  len [0:1];
  wire        pick1;
  wire [2:0]  pick_len;
  wire [10:0] pick_clks;

  // Compatibility space decode: base + 800h + index
  assign in_space = (REG_ADDR[11:4] == `IOWST_SPACE_HI);
  assign idx      = REG_ADDR[3:0];

  // ----------------------------------------------------------------------------
  // Card pin synchroniser
  // ----------------------------------------------------------------------------
  // Two flops, inverted to active high before the first flop
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wide_sync1_reg <= 1'b0;
      wide_sync2_reg <= 1'b0;
    end else begin
      wide_sync1_reg <= ~CARD_WIDE_IO_N;
      wide_sync2_reg <= wide_sync1_reg;
    end
  end

  // ----------------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------------
  // Shared registers: enable and control
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_reg   <= `IOWST_RST_BYTE;
      win_en_reg <= `IOWST_RST_BYTE;
    end else if (REG_WE && in_space) begin
      if (idx == `IOWST_IDX_CTRL) begin
        ctrl_reg <= REG_WDATA;
      end
      if (idx == `IOWST_IDX_WIN_EN) begin
        win_en_reg <= REG_WDATA & `IOWST_EN_RSVD_MASK;
      end
    end
  end

  // Per-window address bytes and window logic
  genvar w;
  generate
    for (w = 0; w < 2; w = w + 1) begin : g_win
      wire [3:0] base = w ? `IOWST_IDX_W1_BASE : `IOWST_IDX_W0_BASE;
      wire       sel  = REG_WE && in_space && (idx[3:2] == base[3:2]);

      // Address bytes, all reset to zero
      always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          start_lo_reg[w] <= `IOWST_RST_BYTE;
          start_hi_reg[w] <= `IOWST_RST_BYTE;
          end_lo_reg[w]   <= `IOWST_RST_BYTE;
          end_hi_reg[w]   <= `IOWST_RST_BYTE;
        end else if (sel) begin
          case (idx[1:0])
            `IOWST_OFS_START_LO: start_lo_reg[w] <= REG_WDATA;
            `IOWST_OFS_START_HI: start_hi_reg[w] <= REG_WDATA;
            `IOWST_OFS_END_LO:   end_lo_reg[w]   <= REG_WDATA;
            default:             end_hi_reg[w]   <= REG_WDATA;
          endcase
        end
      end

      iowst_win u_win (
        .addr       (IO_ADDR),
        .start_addr ({start_hi_reg[w], start_lo_reg[w]}),
        .end_addr   ({end_hi_reg[w], end_lo_reg[w]}),
        .enable     (win_en_reg[w ? `IOWST_BIT_W1_EN : `IOWST_BIT_W0_EN]),
        .ctrl       (ctrl_reg[w*`IOWST_CTRL_NIB_W +: `IOWST_CTRL_NIB_W]),
        .card_wide  (wide_sync2_reg),
        .hit        (hit[w]),
        .wide       (wide[w]),
        .len        (len[w])
      );
    end
  endgenerate

  // Read mux; unmapped indices read zero
  always @* begin
    rdata_next = `IOWST_RST_BYTE;
    if (in_space) begin
      case (idx)
        `IOWST_IDX_WIN_EN:                   rdata_next = win_en_reg;
        `IOWST_IDX_CTRL:                     rdata_next = ctrl_reg;
        `IOWST_IDX_W0_BASE:                  rdata_next = start_lo_reg[0];
        `IOWST_IDX_W0_BASE + 4'h1:           rdata_next = start_hi_reg[0];
        `IOWST_IDX_W0_BASE + 4'h2:           rdata_next = end_lo_reg[0];
        `IOWST_IDX_W0_BASE + 4'h3:           rdata_next = end_hi_reg[0];
        `IOWST_IDX_W1_BASE:                  rdata_next = start_lo_reg[1];
        `IOWST_IDX_W1_BASE + 4'h1:           rdata_next = start_hi_reg[1];
        `IOWST_IDX_W1_BASE + 4'h2:           rdata_next = end_lo_reg[1];
        `IOWST_IDX_W1_BASE + 4'h3:           rdata_next = end_hi_reg[1];
        default:                             rdata_next = `IOWST_RST_BYTE;
      endcase
    end
  end

  // Read data and acknowledge, one cycle after the strobe
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA <= `IOWST_RST_BYTE;
      REG_ACK   <= 1'b0;
    end else begin
      REG_ACK <= REG_WE | REG_RE;
      if (REG_RE) begin
        REG_RDATA <= rdata_next;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Host cycle claim and timing
  // ----------------------------------------------------------------------------
  // Window 0 wins when both match
  assign pick1     = ~hit[0];
  assign pick_len  = pick1 ? len[1] : len[0];
  assign pick_clks = {8'h00, pick_len} * {3'h0, ISA_CLKS};

  // Claim, then hold busy for the chosen number of ISA cycles
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= ST_IDLE;
      count_reg <= 8'h00;
      IO_CLAIM  <= 1'b0;
      IO_WIN1   <= 1'b0;
      IO_WIDE   <= 1'b0;
      IO_BUSY   <= 1'b0;
      IO_DONE   <= 1'b0;
    end else begin
      IO_CLAIM <= 1'b0;
      IO_DONE  <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (IO_REQ && (hit != 2'b00)) begin
            state_reg <= ST_RUN;
            count_reg <= pick_clks[7:0] - 8'h01;
            IO_CLAIM  <= 1'b1;
            IO_WIN1   <= pick1;
            IO_WIDE   <= pick1 ? wide[1] : wide[0];
            IO_BUSY   <= 1'b1;
          end
        end
        ST_RUN: begin
          if (count_reg == 8'h00) begin
            state_reg <= ST_IDLE;
            IO_BUSY   <= 1'b0;
            IO_DONE   <= 1'b1;
          end else begin
            count_reg <= count_reg - 8'h01;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          IO_BUSY   <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== bench/iowst_card.sv
// Card model driving the 16-bit I/O indication pin
`timescale 1ns/100ps
`default_nettype none
module iowst_card #(
  parameter [15:0] WIDE_MASK = 16'h0010  // Address bit of the card's 16-bit ports
) (
  input  wire logic [15:0] io_addr,      // Address presented to the card
  output wire logic        wide_io_n     // 16-bit indication, active low
);
  // Card decodes the address and pulls the pin low for its 16-bit ports
  assign wide_io_n = ((io_addr & WIDE_MASK) == 16'h0000);
endmodule
`default_nettype wire

// ===== bench/iowst_chk.sv
// Port checker for the I/O window block
`timescale 1ns/100ps
`default_nettype none
module iowst_chk (
  input wire logic        CORE_CLK,       // Clock
  input wire logic        SYS_RST,        // Reset
  input wire logic [11:0] REG_ADDR,       // Register offset
  input wire logic        REG_WE,         // Write strobe
  input wire logic        REG_RE,         // Read strobe
  input wire logic [7:0]  REG_WDATA,      // Write data
  input wire logic [7:0]  REG_RDATA,      // Read data
  input wire logic        REG_ACK,        // Access done
  input wire logic        IO_REQ,         // Host request
  input wire logic [15:0] IO_ADDR,        // Host address
  input wire logic        CARD_WIDE_IO_N, // Card pin
  input wire logic        IO_CLAIM,       // Claim pulse
  input wire logic        IO_WIN1,        // Window 1 claimed
  input wire logic        IO_WIDE,        // 16-bit cycle
  input wire logic        IO_BUSY,        // Cycle running
  input wire logic        IO_DONE         // Cycle end
);
  logic [7:0] ctrl_reg;  // Shadow of the control register
  logic [5:0] cnt_reg;   // Busy cycles since claim
  wire  [3:0] nib     = IO_WIN1 ? ctrl_reg[7:4] : ctrl_reg[3:0];
  wire  [5:0] exp_cyc = 6'd7 * (IO_WIDE ? 6'd3 + nib[3] : (nib[2] ? 6'd3 : 6'd4));
  // Track control writes and count busy cycles
  always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_reg <= 8'h00;
      cnt_reg  <= 6'h00;
    end else begin
      if (REG_WE && REG_ADDR == 12'h807)
        ctrl_reg <= REG_WDATA;
      if (IO_CLAIM)
        cnt_reg <= 6'h01;
      else if (IO_BUSY)
        cnt_reg <= cnt_reg + 6'h01;
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  property p_len; IO_DONE |-> cnt_reg == exp_cyc; endproperty
  a_len: assert property (p_len) else $error("cycle length wrong");
  property p_fixed; IO_CLAIM && !nib[1] |-> IO_WIDE == nib[0]; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed width wrong");
  property p_auto; IO_CLAIM && nib[1] |-> IO_WIDE == !$past(CARD_WIDE_IO_N); endproperty
  a_auto: assert property (p_auto) else $error("card width ignored");
  property p_claim; IO_CLAIM |-> $past(IO_REQ) && !$past(IO_BUSY) && IO_BUSY; endproperty
  a_claim: assert property (p_claim) else $error("claim without idle request");
  property p_done; IO_DONE |-> !IO_BUSY && $past(IO_BUSY) ##1 !IO_DONE; endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
  property p_hold; !IO_CLAIM |-> $stable(IO_WIN1) && $stable(IO_WIDE); endproperty
  a_hold: assert property (p_hold) else $error("claim outputs moved");
  property p_unmap; REG_ACK && $past(REG_RE) && $past(REG_ADDR[11:4]) != 8'h80 |-> REG_RDATA == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_ctrl;
    REG_ACK && $past(REG_RE) && !$past(REG_WE) && $past(REG_ADDR) == 12'h807 |-> REG_RDATA == ctrl_reg;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
endmodule
bind iowst_top iowst_chk i_iowst_chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
  .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK),
  .IO_REQ(IO_REQ), .IO_ADDR(IO_ADDR), .CARD_WIDE_IO_N(CARD_WIDE_IO_N), .IO_CLAIM(IO_CLAIM),
  .IO_WIN1(IO_WIN1), .IO_WIDE(IO_WIDE), .IO_BUSY(IO_BUSY), .IO_DONE(IO_DONE));
`default_nettype wire

// ===== bench/iowst_top_tb.sv
// Self-checking bench for the I/O window block
`timescale 1ns/100ps
`default_nettype none
module iowst_top_tb;
  logic        core_clk, sys_rst, reg_we, reg_re, io_req;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [15:0] io_addr;
  logic [31:0] seed;
  logic [7:0]  mreg [16];  // Register model
  wire  [7:0]  reg_rdata;
  wire         reg_ack, card_n, io_claim, io_win1, io_wide, io_busy, io_done;
  int          miscompares, cmp_count, n;

  iowst_top i_iowst_top (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WE(reg_we),
    .REG_RE(reg_re), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_ACK(reg_ack), .IO_REQ(io_req),
    .IO_ADDR(io_addr), .CARD_WIDE_IO_N(card_n), .IO_CLAIM(io_claim), .IO_WIN1(io_win1),
    .IO_WIDE(io_wide), .IO_BUSY(io_busy), .IO_DONE(io_done));
  iowst_card i_iowst_card (.io_addr(io_addr), .wide_io_n(card_n));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_len(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      miscompares++;
      $display("Error at %0t: cycle %0d expected %0d", $time, got, exp);
    end
  endtask
  // One register access, read data compared with the model
  task automatic acc(input logic we, input logic [11:0] ad, input logic [7:0] d);
    logic [7:0] e;
    e = (ad[11:4] != 8'h80 || ad[3:0] < 4'h6) ? 8'h00 : (ad[3:0] == 4'h6 ? mreg[6] & 8'hdf : mreg[ad[3:0]]);
    @(negedge core_clk);
    reg_we = we;
    reg_re = !we;
    reg_addr = ad;
    reg_wdata = d;
    @(negedge core_clk);
    reg_we = 1'b0;
    reg_re = 1'b0;
    chk(8'(reg_ack), 8'h01);
    if (!we)
      chk(reg_rdata, e);
    else if (ad[11:4] == 8'h80 && ad[3:0] >= 4'h6)
      mreg[ad[3:0]] = d;
  endtask
  // One host cycle, claim, width and length compared with the model
  task automatic io(input logic [15:0] ad);
    logic       h0, h1, wd;
    logic [3:0] nb;
    int         len;
    h0 = mreg[6][6] && ad >= {mreg[9], mreg[8]} && ad <= {mreg[11], mreg[10]};
    h1 = mreg[6][7] && ad >= {mreg[13], mreg[12]} && ad <= {mreg[15], mreg[14]};
    nb = h0 ? mreg[7][3:0] : mreg[7][7:4];
    wd = nb[1] ? ((ad & 16'h0010) != 16'h0000) : nb[0];
    len = 7 * (wd ? 3 + nb[3] : (nb[2] ? 3 : 4));
    @(negedge core_clk);
    io_addr = ad;
    repeat (3) @(negedge core_clk);
    io_req = 1'b1;
    @(negedge core_clk);
    io_req = 1'b0;
    chk(8'(io_claim), 8'(h0 | h1));
    if (h0 | h1) begin
      chk(8'(io_win1), 8'(!h0));
      chk(8'(io_wide), 8'(wd));
      n = 0;
      while (io_done !== 1'b1 && n < 40) begin
        @(negedge core_clk);
        n++;
      end
      chk_len(n, len);
    end
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Watchdog
  initial begin
    #1000000;
    miscompares++;
    end_sim();
  end
  // Main sequence
  initial begin
    {sys_rst, reg_we, reg_re, io_req, reg_addr, reg_wdata, io_addr} = {4'h8, 36'h0};
    seed = 32'h4c01;
    miscompares = 0;
    cmp_count = 0;
    foreach (mreg[i]) mreg[i] = 8'h00;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 16; i++) acc(1'b0, 12'(12'h800 + i), 8'h00);
    for (int i = 0; i < 16; i++) acc(1'b1, 12'(12'h800 + i), 8'(rnd()));
    acc(1'b1, 12'h907, 8'hff);
    for (int i = 0; i < 16; i++) acc(1'b0, 12'(12'h800 + i), 8'h00);
    acc(1'b0, 12'h907, 8'h00);
    acc(1'b1, 12'h806, 8'h00);
    for (int i = 0; i < 8; i++) acc(1'b1, 12'(12'h808 + i), 8'(64'h02ff0200033f0300 >> (8 * i)));
    io(16'h0310);
    acc(1'b1, 12'h806, 8'hc0);
    for (int c = 0; c < 16; c++) begin
      // Different nibbles per window, so a swapped nibble shows up
      acc(1'b1, 12'h807, {4'(c), 4'(~c)});
      io(16'h0300);
      io(16'h033f);
      io(16'h0340);
      io(16'h02ff);
      io(16'h0200);
      io(16'(rnd()) & 16'h03ff);
    end
    end_sim();
  end
endmodule
`default_nettype wire
